// ==== tb/system_clock_power_mode_ctrl_tb.sv ====
/*
  Bench for scpm_ctrl: APB register access, frequency and clock select, halt and wake.
  Assumes scpm_pkg is compiled first; oscillator clocks are derived from pclk.
*/
`timescale 1ns/1ps
`define CHK(nm, x, g) begin checks_done++; if ((g) !== (x)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, x, g); end end
module system_clock_power_mode_ctrl_tb;
  localparam logic [11:0] SYS_A = scpm_pkg::ADDR_SYS_CLK_CTRL;
  localparam logic [11:0] RC_A = scpm_pkg::ADDR_FAST_RC_CTRL;
  localparam int STAB = scpm_pkg::FAST_STAB_CYCLES + 4;
  typedef struct {string nm; logic [31:0] d; logic e;} scpm_note_t;
  scpm_note_t notes[$];
  scpm_note_t nt;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int rises = 0;
  int n, r0, t0, bnd, per, pt, seed, p;
  logic [2:0] sels [4];
  logic [2:0] s;
  logic [2:0] cnt = 3'h0;
  logic [1:0] pf;
  // bus and clock signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, fast_osc_run, slow_osc_run;
  logic fast_rc_clk = 1'b0, slow_rc_clk = 1'b0, slow_rc_ready = 1'b1;
  logic [1:0] fast_osc_freq;
  // halt, wake and status
  logic halt_req = 1'b0, irq_req = 1'b0, wdt_overflow = 1'b0, wdt_enable = 1'b0;
  logic [7:0] wake_pin_n = 8'hff, wake_pin_en = 8'h00;
  logic sys_clk, sys_rise, clk_switching, cpu_run, fsub_clk_en, fh_periph_en;
  logic power_down_set, timeout_flag_clr, watchdog_clr;

  scpm_ctrl #(.PINS(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fast_rc_clk, .slow_rc_clk, .slow_rc_ready,
    .fast_osc_run, .fast_osc_freq, .slow_osc_run, .halt_req, .irq_req, .wdt_overflow,
    .wdt_enable, .wake_pin_n, .wake_pin_en, .sys_clk, .sys_rise, .clk_switching,
    .cpu_run, .fsub_clk_en, .fh_periph_en, .power_down_set, .timeout_flag_clr,
    .watchdog_clr);

  always #10 pclk = ~pclk;

  // oscillators from a pclk counter: fast period 4 cycles, slow period 16
  always @(posedge pclk) begin
    cnt <= cnt + 3'h1;
    if (cnt[0]) fast_rc_clk <= ~fast_rc_clk;
    if (cnt == 3'h7) slow_rc_clk <= ~slow_rc_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // answer watcher: every completed transfer consumes the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (sys_rise === 1'b1) rises++;
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      `CHK(nt.nm, nt.d, prdata)
      `CHK(nt.nm, nt.e, pslverr)
    end
    if (cyc == 30000) begin
      fail_count++;
      $display("[FAIL] timeout expected done seen hang");
      test_done();
    end
  end

  // one apb transfer; waits for pready as long as it takes, the bench timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic e, input string nm);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    notes.push_back('{nm, x, e});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    seed = $urandom(32'h51fdacf1);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, loose bits, unmapped place
    apb(0, SYS_A, 0, 32'h0, 0, "sys reset");
    apb(0, RC_A, 0, 32'h1, 0, "rc reset");
    apb(1, SYS_A, 32'h1f, 0, 0, "sys wr");
    apb(0, SYS_A, 0, 32'h3, 0, "sys loose");
    apb(1, RC_A, 32'hf3, 0, 0, "rc wr");
    apb(0, RC_A, 0, 32'h1, 0, "rc loose");
    apb(1, 12'h008, 32'hff, 0, 1, "hole wr");
    apb(0, 12'h008, 0, 0, 1, "hole rd");
    apb(1, SYS_A, 0, 0, 0, "sys clr");
    $display("test registers done");
    // every frequency code, ending on code 0 as configured; frequency follows the flag
    pf = 2'h0;
    for (int i = 1; i <= 4; i++) begin
      apb(1, RC_A, {28'h0, i[1:0], 2'h1}, 0, 0, "freq wr");
      apb(0, RC_A, 0, {28'h0, i[1:0], 2'h1}, 0, "flag low");
      `CHK("freq held", (pf == 2'h3) ? 2'h0 : pf, fast_osc_freq)
      repeat (STAB) @(posedge pclk);
      apb(0, RC_A, 0, {28'h0, i[1:0], 2'h3}, 0, "flag high");
      `CHK("freq", (i[1:0] == 2'h3) ? 2'h0 : i[1:0], fast_osc_freq)
      pf = i[1:0];
    end
    $display("test frequency done");
    // clock select: switch time, slow readiness and divided period
    sels = '{3'h1, 3'h7, 3'($urandom_range(6, 2)), 3'h0};
    per = 4;
    foreach (sels[k]) begin
      s = sels[k];
      pt = (s == 3'h7) ? 16 : (4 << s);
      slow_rc_ready <= (s != 3'h7);
      t0 = cyc;
      bnd = (11 * per + pt) / 2 + 10;
      apb(1, SYS_A, {24'h0, s, 5'h0}, 0, 0, "sel wr");
      repeat (2) @(posedge pclk);
      `CHK("switching", 1'b1, clk_switching)
      if (s == 3'h7) begin
        repeat (200) @(posedge pclk);
        `CHK("slow unready", 1'b1, clk_switching)
        slow_rc_ready <= 1'b1;
        t0 = cyc;
        bnd = pt + 12;
      end
      n = 0;
      while (clk_switching !== 1'b0 && n < 3000) begin @(posedge pclk); n++; end
      `CHK("switch time", 1'b1, cyc - t0 <= bnd)
      n = 0;
      while (sys_rise !== 1'b1 && n < 600) begin @(posedge pclk); n++; end
      n = 0;
      do begin @(posedge pclk); n++; end while (sys_rise !== 1'b1 && n < 600);
      `CHK("sys period", pt, n)
      per = pt;
    end
    $display("test clock select done");
    // the four halt modes, woken by the watchdog, a pin or an interrupt (modes 1 and 3 both by interrupt)
    for (int m = 0; m < 4; m++) begin
      wdt_enable <= (m == 0); // watchdog alone must keep the slow oscillator
      apb(1, SYS_A, m, 0, 0, "idle wr");
      @(posedge pclk);
      halt_req <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
      @(posedge pclk);
      `CHK("cpu stop", 1'b0, cpu_run)
      `CHK("pdf set", 1'b1, power_down_set)
      `CHK("tof clr", 1'b1, timeout_flag_clr)
      `CHK("wd clr", 1'b1, watchdog_clr)
      `CHK("slow per", m[0], fsub_clk_en)
      `CHK("fast osc", m[1], fast_osc_run)
      `CHK("slow osc", m[0] | (m == 0), slow_osc_run)
      @(posedge pclk);
      `CHK("pdf pulse", 1'b0, power_down_set)
      repeat (20) @(posedge pclk);
      r0 = rises;
      repeat (64) @(posedge pclk);
      `CHK("sys in halt", m[1], rises != r0)
      if (!m[1]) `CHK("sys stop low", 1'b0, sys_clk)
      `CHK("fast per", m[1], fh_periph_en)
      p = $urandom_range(7, 0);
      case (m)
        0: wdt_overflow <= 1'b1;
        2: begin
          wake_pin_en <= 8'h1 << p;
          wake_pin_n <= ~(8'h1 << p);
        end
        default: irq_req <= 1'b1;
      endcase
      @(posedge pclk);
      wdt_overflow <= 1'b0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 12) begin @(posedge pclk); n++; end
      `CHK("wake", 1'b1, cpu_run)
      irq_req <= 1'b0;
      wake_pin_n <= 8'hff;
      apb(0, SYS_A, 0, m, 0, "regs kept");
      repeat (STAB) @(posedge pclk); // fast oscillator may restart after wake
    end
    $display("test halt modes done");
    test_done();
  end
endmodule // system_clock_power_mode_ctrl_tb

// ==== verilog/scpm_clk_sw.sv ====
/*
  scpm_clk_sw: glitch-free system clock divider and source switch.
  Assumes fast_tr and slow_tr are one-cycle pulses on every transition
  of the synchronised oscillator clocks, in the clk domain.
*/
`timescale 1ns/1ps
module scpm_clk_sw (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // source transitions and readiness
  input wire logic fast_tr,
  input wire logic slow_tr,
  input wire logic fast_ok,
  input wire logic slow_ok,
  // control
  input wire logic [2:0] target_sel,
  input wire logic gate,
  // generated clock
  output logic sys_clk,
  output logic sys_rise,
  output logic switching,
  output logic [2:0] cur_sel
);

  logic [5:0] div_cnt;
  logic [5:0] div_last;
  logic [2:0] per_cnt;
  logic src_tr;
  logic tar_tr;
  logic tar_ok;
  logic pending;
  logic parked;
  logic toggle;
  logic swap;

  // source, divider end and switch conditions
  always_comb begin
    src_tr = (cur_sel == scpm_pkg::SEL_SLOW) ? slow_tr : fast_tr;
    tar_tr = (target_sel == scpm_pkg::SEL_SLOW) ? slow_tr : fast_tr;
    tar_ok = (target_sel == scpm_pkg::SEL_SLOW) ? slow_ok : fast_ok;
    div_last = (cur_sel == scpm_pkg::SEL_SLOW) ? 6'h00 : 6'((7'h01 << cur_sel) - 7'h01);
    pending = target_sel != cur_sel;
    // after four rises, with the target ready, the clock is parked low; waiting
    // for a target edge that misses every source edge could stall forever
    parked = pending && (per_cnt == scpm_pkg::SWITCH_PERIODS) && !sys_clk && tar_ok;
    // the gate only ever stops the clock low, so a high phase is never cut
    toggle = src_tr && (div_cnt == div_last) && (sys_clk || gate) && !parked;
    // swap at the first target edge while parked, so the next high is whole
    swap = parked && tar_tr;
  end

  // divider counts source transitions; held while gated low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 6'h00;
    end else if (swap) begin
      div_cnt <= 6'h00;
    end else if (src_tr && (sys_clk || gate)) begin
      div_cnt <= (div_cnt == div_last) ? 6'h00 : div_cnt + 6'h01;
    end
  end

  // system clock level and its rising-edge pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk <= 1'b0;
      sys_rise <= 1'b0;
    end else begin
      sys_clk <= toggle ? !sys_clk : sys_clk;
      sys_rise <= toggle && !sys_clk;
    end
  end

  // current periods counted after a new select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt <= 3'h0;
    end else if (!pending || swap) begin
      per_cnt <= 3'h0;
    end else if (toggle && !sys_clk && per_cnt != scpm_pkg::SWITCH_PERIODS) begin
      per_cnt <= per_cnt + 3'h1;
    end
  end

  // adopted select and busy status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_sel <= scpm_pkg::SEL_RST;
      switching <= 1'b0;
    end else begin
      cur_sel <= swap ? target_sel : cur_sel;
      switching <= pending && !swap;
    end
  end

  a_clk_edge_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_clk != $past(sys_clk)) |-> $past(src_tr))
    else $error("system clock moved without a source transition");

  a_swap_in_low: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_sel != $past(cur_sel)) |-> !sys_clk && !$past(sys_clk))
    else $error("clock source swapped during a high phase");

endmodule // scpm_clk_sw

// ==== verilog/scpm_ctrl.sv ====
/*
  scpm_ctrl: system clock and power mode controller with an APB
  register slave, fast oscillator control and halt/wake sequencing.
  Assumes the oscillator clocks and port pins are asynchronous to pclk,
  and halt_req, irq_req, wdt_overflow, wdt_enable come from pclk logic.
*/
`timescale 1ns/1ps

module scpm_ctrl #(
  parameter int PINS = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillators
  input wire logic fast_rc_clk,
  input wire logic slow_rc_clk,
  input wire logic slow_rc_ready,
  output logic fast_osc_run,
  output logic [1:0] fast_osc_freq,
  output logic slow_osc_run,
  // cpu, watchdog and wake sources
  input wire logic halt_req,
  input wire logic irq_req,
  input wire logic wdt_overflow,
  input wire logic wdt_enable,
  input wire logic [PINS-1:0] wake_pin_n,
  input wire logic [PINS-1:0] wake_pin_en,
  // clocks and power status
  output logic sys_clk,
  output logic sys_rise,
  output logic clk_switching,
  output logic cpu_run,
  output logic fsub_clk_en,
  output logic fh_periph_en,
  output logic power_down_set,
  output logic timeout_flag_clr,
  output logic watchdog_clr
);

  localparam int SYNC_W = PINS + 3;
  localparam int CNT_W = $clog2(scpm_pkg::FAST_STAB_CYCLES + 1);
  localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(scpm_pkg::FAST_STAB_CYCLES - 1);
  localparam int A_STAB_WAIT = scpm_pkg::FAST_STAB_CYCLES + 2;

  // software-visible state
  logic [2:0] sys_clk_sel;
  logic fast_osc_idle_en;
  logic slow_osc_idle_en;
  logic [1:0] fast_rc_freq_sel;
  logic fast_rc_enable;
  logic fast_rc_stable_flag;
  logic [CNT_W-1:0] stab_cnt;

  // mode state
  scpm_pkg::scpm_mode_t mode;
  scpm_pkg::scpm_mode_t next_mode;

  // synchronisers and derived events
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] sync_c;
  logic fast_tr;
  logic slow_tr;
  logic slow_ready;
  logic [PINS-1:0] pin_fall;
  logic wake;
  logic halt_go;

  // bus and clock switch wires
  logic wr_en;
  logic wr_scc;
  logic wr_rc;
  logic mapped;
  logic rc_restart;
  logic [31:0] rd_word;
  logic [2:0] cur_sel;
  logic sys_gate;
  logic fast_keep;
  logic slow_keep;

  // two-stage synchronisers; a third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= {wake_pin_n, slow_rc_ready, slow_rc_clk, fast_rc_clk};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // transitions of the oscillator clocks and falling pin edges
  always_comb begin
    fast_tr = sync_b[0] ^ sync_c[0];
    slow_tr = sync_b[1] ^ sync_c[1];
    slow_ready = sync_b[2];
    pin_fall = sync_c[3 +: PINS] & ~sync_b[3 +: PINS];
    wake = (|(pin_fall & wake_pin_en)) || irq_req || wdt_overflow;
    halt_go = (mode == scpm_pkg::mode_run) && halt_req;
  end

  // apb decode; writes land only at the completing access edge
  always_comb begin
    wr_en = psel && penable && pready && pwrite;
    mapped = (paddr == scpm_pkg::ADDR_SYS_CLK_CTRL) || (paddr == scpm_pkg::ADDR_FAST_RC_CTRL);
    wr_scc = wr_en && (paddr == scpm_pkg::ADDR_SYS_CLK_CTRL);
    wr_rc = wr_en && (paddr == scpm_pkg::ADDR_FAST_RC_CTRL);
    // enabling, or retuning while enabled, invalidates the stable flag
    rc_restart = wr_rc && pwdata[scpm_pkg::RC_EN_BIT]
                 && (!fast_rc_enable
                     || pwdata[scpm_pkg::RC_FREQ_LSB +: 2] != fast_rc_freq_sel);
  end

  // read data; unlisted bits stay zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr == scpm_pkg::ADDR_SYS_CLK_CTRL) begin
      rd_word[scpm_pkg::SCC_SEL_LSB +: 3] = sys_clk_sel;
      rd_word[scpm_pkg::SCC_FAST_IDLE_BIT] = fast_osc_idle_en;
      rd_word[scpm_pkg::SCC_SLOW_IDLE_BIT] = slow_osc_idle_en;
    end else if (paddr == scpm_pkg::ADDR_FAST_RC_CTRL) begin
      rd_word[scpm_pkg::RC_FREQ_LSB +: 2] = fast_rc_freq_sel;
      rd_word[scpm_pkg::RC_STABLE_BIT] = fast_rc_stable_flag;
      rd_word[scpm_pkg::RC_EN_BIT] = fast_rc_enable;
    end
  end

  // no wait state: data and answer are registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // system clock control register; halt does not touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_sel <= scpm_pkg::SEL_RST;
      fast_osc_idle_en <= scpm_pkg::FAST_IDLE_RST;
      slow_osc_idle_en <= scpm_pkg::SLOW_IDLE_RST;
    end else if (wr_scc) begin
      sys_clk_sel <= pwdata[scpm_pkg::SCC_SEL_LSB +: 3];
      fast_osc_idle_en <= pwdata[scpm_pkg::SCC_FAST_IDLE_BIT];
      slow_osc_idle_en <= pwdata[scpm_pkg::SCC_SLOW_IDLE_BIT];
    end
  end

  // fast oscillator control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_rc_freq_sel <= scpm_pkg::FREQ_RST;
      fast_rc_enable <= scpm_pkg::FAST_EN_RST;
    end else if (wr_rc) begin
      fast_rc_freq_sel <= pwdata[scpm_pkg::RC_FREQ_LSB +: 2];
      fast_rc_enable <= pwdata[scpm_pkg::RC_EN_BIT];
    end
  end

  // stable flag: cleared whenever the oscillator is off or restarted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_rc_stable_flag <= 1'b0;
      stab_cnt <= '0;
    end else if (!fast_osc_run || rc_restart) begin
      fast_rc_stable_flag <= 1'b0;
      stab_cnt <= '0;
    end else if (!fast_rc_stable_flag) begin
      fast_rc_stable_flag <= stab_cnt == STAB_LAST;
      stab_cnt <= (stab_cnt == STAB_LAST) ? stab_cnt : stab_cnt + CNT_W'(1);
    end
  end

  // trim code moves only as the flag sets; the spare code means 2 MHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_freq <= scpm_pkg::FREQ_2M;
    end else if (fast_osc_run && !rc_restart && !fast_rc_stable_flag
                 && stab_cnt == STAB_LAST) begin
      fast_osc_freq <= (fast_rc_freq_sel == scpm_pkg::FREQ_2M_ALT)
                       ? scpm_pkg::FREQ_2M : fast_rc_freq_sel;
    end
  end

  // halt picks the low-power mode from the idle bits; wake returns to run
  always_comb begin
    next_mode = mode;
    unique case (mode)
      scpm_pkg::mode_run: begin
        if (halt_req) begin
          unique case ({fast_osc_idle_en, slow_osc_idle_en})
            2'b00: next_mode = scpm_pkg::mode_sleep;
            2'b01: next_mode = scpm_pkg::mode_idle_slow_only;
            2'b10: next_mode = scpm_pkg::mode_idle_fast_only;
            2'b11: next_mode = scpm_pkg::mode_idle_both_clocks;
          endcase
        end
      end
      scpm_pkg::mode_sleep,
      scpm_pkg::mode_idle_slow_only,
      scpm_pkg::mode_idle_both_clocks,
      scpm_pkg::mode_idle_fast_only: begin
        if (wake) begin
          next_mode = scpm_pkg::mode_run;
        end
      end
    endcase
  end

  // mode register; nothing else is reset on entry, so state is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= scpm_pkg::mode_run;
    end else begin
      mode <= next_mode;
    end
  end

  // halt-entry pulses to the status register and the watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_set <= 1'b0;
      timeout_flag_clr <= 1'b0;
      watchdog_clr <= 1'b0;
    end else begin
      power_down_set <= halt_go;
      timeout_flag_clr <= halt_go;
      watchdog_clr <= halt_go;
    end
  end

  // which oscillators the coming mode keeps
  always_comb begin
    fast_keep = (next_mode == scpm_pkg::mode_run)
                || (next_mode == scpm_pkg::mode_idle_fast_only)
                || (next_mode == scpm_pkg::mode_idle_both_clocks);
    slow_keep = (next_mode == scpm_pkg::mode_run)
                || (next_mode == scpm_pkg::mode_idle_slow_only)
                || (next_mode == scpm_pkg::mode_idle_both_clocks);
    // in halt the system clock runs only if its own source is kept
    sys_gate = (mode == scpm_pkg::mode_run)
               || ((cur_sel == scpm_pkg::SEL_SLOW)
                   ? (mode == scpm_pkg::mode_idle_slow_only
                      || mode == scpm_pkg::mode_idle_both_clocks)
                   : (mode == scpm_pkg::mode_idle_fast_only
                      || mode == scpm_pkg::mode_idle_both_clocks));
  end

  // oscillator and clock enables; the slow one also serves the watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_run <= 1'b1;
      slow_osc_run <= 1'b1;
      fsub_clk_en <= 1'b1;
      fh_periph_en <= 1'b0;
      cpu_run <= 1'b1;
    end else begin
      // a fast select keeps the oscillator alive even with the enable low
      fast_osc_run <= fast_keep && (fast_rc_enable || sys_clk_sel != scpm_pkg::SEL_SLOW
                                    || cur_sel != scpm_pkg::SEL_SLOW);
      slow_osc_run <= slow_keep || wdt_enable;
      fsub_clk_en <= slow_keep;
      fh_periph_en <= fast_keep && fast_rc_stable_flag;
      cpu_run <= next_mode == scpm_pkg::mode_run;
    end
  end

  // divider and glitch-free source switch
  scpm_clk_sw u_clk_sw (
    .clk(pclk),
    .rst_n(presetn),
    .fast_tr(fast_tr),
    .slow_tr(slow_tr),
    .fast_ok(fast_rc_stable_flag),
    .slow_ok(slow_ready),
    .target_sel(sys_clk_sel),
    .gate(sys_gate),
    .sys_clk(sys_clk),
    .sys_rise(sys_rise),
    .switching(clk_switching),
    .cur_sel(cur_sel)
  );

  sequence s_halt_entry;
    (mode == scpm_pkg::mode_run) && halt_req;
  endsequence

  sequence s_entry_pulses;
    power_down_set && timeout_flag_clr && watchdog_clr ##1 !power_down_set;
  endsequence

  a_halt_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_entry and (!fast_osc_idle_en && !slow_osc_idle_en)
    |=> mode == scpm_pkg::mode_sleep && !cpu_run && !fsub_clk_en)
    else $error("halt with both idle bits low did not sleep");

  a_halt_fast_idle: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_entry and (fast_osc_idle_en && !slow_osc_idle_en)
    |=> mode == scpm_pkg::mode_idle_fast_only && !fsub_clk_en)
    else $error("halt with fast idle only took the wrong mode");

  a_halt_slow_idle: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_entry and (!fast_osc_idle_en && slow_osc_idle_en)
    |=> mode == scpm_pkg::mode_idle_slow_only && fsub_clk_en && !fast_osc_run)
    else $error("halt with slow idle only took the wrong mode");

  a_halt_both_idle: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_entry and (fast_osc_idle_en && slow_osc_idle_en)
    |=> mode == scpm_pkg::mode_idle_both_clocks && fsub_clk_en && !cpu_run)
    else $error("halt with both idle bits took the wrong mode");

  a_entry_flags: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_entry |=> s_entry_pulses)
    else $error("halt entry pulses missing or too long");

  a_stable_restart: assert property (@(posedge pclk) disable iff (!presetn)
    rc_restart |=> !fast_rc_stable_flag)
    else $error("stable flag not cleared on enable or retune");

  a_stable_bound: assert property (@(posedge pclk) disable iff (!presetn)
    fast_osc_run && !fast_rc_stable_flag
    |-> ##[1:A_STAB_WAIT] (fast_rc_stable_flag || !fast_osc_run || rc_restart))
    else $error("stable flag never set after restart");

  a_freq_after_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(fast_osc_freq) |-> $rose(fast_rc_stable_flag))
    else $error("frequency applied without the stable flag");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && !pwrite
    |-> prdata[31:8] == 24'h000000 && (paddr != scpm_pkg::ADDR_SYS_CLK_CTRL
        || prdata[4:2] == 3'h0) && (paddr != scpm_pkg::ADDR_FAST_RC_CTRL
        || prdata[7:4] == 4'h0))
    else $error("unimplemented bits read as one");

  a_wake_return: assert property (@(posedge pclk) disable iff (!presetn)
    (mode != scpm_pkg::mode_run) && wake |=> mode == scpm_pkg::mode_run && cpu_run)
    else $error("wake event did not return to run");

  a_slow_for_wdt: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_enable [*2] |-> slow_osc_run)
    else $error("slow oscillator stopped while watchdog enabled");

endmodule // scpm_ctrl

// ==== verilog/scpm_pkg.sv ====
/*
  scpm_pkg: register map, field positions, reset values, mode and
  timing constants of the system clock and power mode controller.
  Assumes a 50 MHz APB clock; oscillator timing is counted in it.
*/
package scpm_pkg;

  // register byte offsets on the APB bus
  localparam logic [11:0] ADDR_SYS_CLK_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FAST_RC_CTRL = 12'h004;

  // system_clock_control fields
  localparam int SCC_SEL_LSB = 5;
  localparam int SCC_FAST_IDLE_BIT = 1;
  localparam int SCC_SLOW_IDLE_BIT = 0;

  // fast_rc_osc_control fields
  localparam int RC_FREQ_LSB = 2;
  localparam int RC_STABLE_BIT = 1;
  localparam int RC_EN_BIT = 0;

  // values after reset
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic FAST_IDLE_RST = 1'h0;
  localparam logic SLOW_IDLE_RST = 1'h0;
  localparam logic [1:0] FREQ_RST = 2'h0;
  localparam logic FAST_EN_RST = 1'h1;

  // clock select code for the slow clock; lower codes divide the fast one
  localparam logic [2:0] SEL_SLOW = 3'h7;

  // fast oscillator frequency codes
  localparam logic [1:0] FREQ_2M = 2'h0;
  localparam logic [1:0] FREQ_4M = 2'h1;
  localparam logic [1:0] FREQ_8M = 2'h2;
  localparam logic [1:0] FREQ_2M_ALT = 2'h3;

  // timing
  localparam int CLK_HZ = 50000000;
  localparam int FAST_STAB_NS = 16000;
  localparam int FAST_STAB_CYCLES = (FAST_STAB_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [2:0] SWITCH_PERIODS = 3'h4;

  // operating modes
  typedef enum logic [2:0] {
    mode_run,
    mode_sleep,
    mode_idle_slow_only,
    mode_idle_both_clocks,
    mode_idle_fast_only
  } scpm_mode_t;

endpackage
